// >>> temperature_measure_sequencer_test.sv
// self-checking bench for the temperature measurement sequencer
`include "tmseq_defs.vh"
module temperature_measure_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int C = 20, S = 10;
  localparam logic [10:0] REF = 11'h3A5; // arbitrary reference value
  localparam logic [15:0] CTL = `TMSEQ_IDX_CONTROL, TRG = `TMSEQ_IDX_TRIGGER;
  localparam logic [15:0] STS = `TMSEQ_IDX_IRQ_STATUS;
  logic        sys_clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, sleep_mode = 0;
  logic [17:0] adr = 0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] dat = 0;
  logic [7:0]  q, cv = 0, nv;
  logic [10:0] v;
  wire  [31:0] wb_dat_o;
  wire  [10:0] conv_result;
  wire         wb_ack_o, conv_start, conv_done, battery_measure_en, sensor_power_sel, irq;
  int          mismatches = 0, n_compared = 0, starts = 0, cycle = 0, t0, i, p;
  tmseq_core #(.REF22_VALUE(REF), .COMMIT_CYCLES(C), .SECOND_CYCLES(S)) tmseq_core_i (
    .sys_clk, .sys_rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o, .sleep_mode, .conv_start,
    .conv_done, .conv_result, .battery_measure_en, .sensor_power_sel, .irq);
  tmseq_conv_model tmseq_conv_model_i (.sys_clk, .conv_start, .conv_done, .conv_result);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycle <= cycle + 1;
    if (conv_start === 1'b1) starts <= starts + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    {cyc, stb, we, adr, dat} <= {2'b11, w, idx, 2'b00, 24'h0, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1 && ++t < 50);
    if (wb_ack_o !== 1'b1) mismatches++;
    q = wb_dat_o[7:0];
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic rd(input string nm, input logic [15:0] idx, input logic [7:0] exp);
    wb(0, idx, 0);
    chk(nm, q, exp);
  endtask
  task automatic idle(input logic [15:0] idx, input int b);
    int t;
    t = 0;
    do wb(0, idx, 0); while (q[b] !== 1'b0 && ++t < 100);
    if (q[b] !== 1'b0) mismatches++;
  endtask
  task automatic wstart;
    int t;
    t = 0;
    do @(posedge sys_clk); while (conv_start !== 1'b1 && ++t < 2000);
    if (conv_start !== 1'b1) mismatches++;
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h2A75));
    repeat (5) @(posedge sys_clk);
    sys_rst <= 0;
    rd("ctl", CTL, 8'h00);
    rd("rhi", `TMSEQ_IDX_REF22_HIGH, {5'h0, REF[10:8]});
    rd("rlo", `TMSEQ_IDX_REF22_LOW, REF[7:0]);
    rd("unmapped", 16'h2000, 8'h00);
    for (i = 0; i < 2; i++) begin
      nv = {1'b0, i[0], 1'b0, 1'($urandom), 4'h0};
      wb(1, CTL, nv);
      rd("busy", CTL, cv | 8'h08);
      wb(1, CTL, 8'h77);
      cv = nv;
      idle(CTL, 3);
      chk("ctl", q, cv);
      chk("bat", battery_measure_en, cv[4]);
      chk("pwr", sensor_power_sel, i[0]);
    end
    rd("sts", STS, 8'h02);
    wb(1, `TMSEQ_IDX_IRQ_MASK, 8'h03);
    chk("irq", irq, 1);
    wb(1, STS, 8'h02);
    chk("irq", irq, 0);
    v = 11'($urandom);
    tmseq_conv_model_i.value = v;
    tmseq_conv_model_i.slow = $urandom % 4;
    t0 = starts;
    wb(1, TRG, 8'h40);
    rd("trg", TRG, 8'h40);
    idle(TRG, 6);
    chk("oneshot", starts - t0, 1);
    rd("res_hi", `TMSEQ_IDX_RESULT_HIGH, v[10:3]);
    rd("res_lo", `TMSEQ_IDX_RESULT_LOW, {v[2:0], 5'h0});
    rd("sts", STS, 8'h01);
    chk("irq", irq, 1);
    wb(1, STS, 8'h01);
    sleep_mode <= 1;
    repeat (3) @(posedge sys_clk);
    t0 = starts;
    wb(1, TRG, 8'h40);
    repeat (400) @(posedge sys_clk);
    chk("idle", starts - t0, 0);
    rd("trg", TRG, 8'h00);
    chk("pwr", sensor_power_sel, 0);
    for (p = 1; p <= 2; p++) begin
      sleep_mode <= p == 1;
      wb(1, CTL, 8'(p));
      idle(CTL, 3);
      wstart;
      t0 = cycle;
      wstart;
      chk("period", cycle - t0, S << (3 + p));
    end
    wb(1, CTL, 8'h07);
    idle(CTL, 3);
    t0 = starts;
    repeat (100) @(posedge sys_clk);
    chk("continuous", starts - t0 > 5, 1);
    print_verdict;
  end
endmodule

// >>> tmseq_conv_model.sv
// behavioural temperature converter answering conversion starts
module tmseq_conv_model (
  input  wire logic        sys_clk,
  input  wire logic        conv_start,
  output logic             conv_done,
  output logic [10:0]      conv_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [10:0] value = 11'h5A5;
  int          slow  = 0;
  int          cnt   = -1;
  initial conv_done = 1'b0;
  initial conv_result = 11'h000;
  // result is only guaranteed around the done pulse, garbage otherwise
  always @(posedge sys_clk) begin
    if (conv_start) cnt <= 0;
    else if (cnt >= 0) cnt <= cnt + 1;
    if (cnt == 2 + slow) conv_result <= value;
    if (cnt == 2 + slow) conv_done <= 1'b1;
    if (cnt == 4 + slow) conv_done <= 1'b0;
    if (cnt == 7 + slow) conv_result <= ~value;
  end
endmodule

// >>> tmseq_core.v
// temperature measurement sequencer with classic wishbone register slave
`include "tmseq_defs.vh"
module tmseq_core #(
  parameter        ADR_W         = 18,
  parameter [10:0] REF22_VALUE   = 11'h000,
  parameter        COMMIT_CYCLES = `TMSEQ_COMMIT_CYCLES,
  parameter        SECOND_CYCLES = `TMSEQ_SECOND_CYCLES
) (
  input  wire              sys_clk,
  input  wire              sys_rst,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [ADR_W-1:0]  wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire              sleep_mode,
  output reg               conv_start,
  input  wire              conv_done,
  input  wire [10:0]       conv_result,
  output wire              battery_measure_en,
  output wire              sensor_power_sel,
  output wire              irq
);

  // ============================================================
  // state machine codes
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  reg        [2:0] state;
  reg        [2:0] next_state;

  // ============================================================
  // synchronisers for inputs from the analog side
  reg        sleep_meta;
  reg        sleep_sync;
  reg        done_meta;
  reg        done_sync;
  reg        done_prev;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      done_meta  <= 1'b0;
      done_sync  <= 1'b0;
      done_prev  <= 1'b0;
    end else begin
      sleep_meta <= sleep_mode;
      sleep_sync <= sleep_meta;
      done_meta  <= conv_done;
      done_sync  <= done_meta;
      done_prev  <= done_sync;
    end
  end
  wire done_rise = done_sync & ~done_prev;

  // converter result passes two flops before the capture register reads it
  reg [10:0] res_meta;
  reg [10:0] res_sync;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_meta <= 11'h000;
      res_sync <= 11'h000;
    end else begin
      res_meta <= conv_result;
      res_sync <= res_meta;
    end
  end

  // ============================================================
  // bus decode
  function hit;
    input [ADR_W-1:0] adr;
    input [15:0]      idx;
    begin
      hit = (adr[ADR_W-1:2] == idx[ADR_W-3:0]) && (adr[1:0] == 2'b00);
    end
  endfunction

  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctl   = wr_lane0 & hit(wb_adr_i, `TMSEQ_IDX_CONTROL);
  wire wr_trg   = wr_lane0 & hit(wb_adr_i, `TMSEQ_IDX_TRIGGER);
  wire wr_ists  = wr_lane0 & hit(wb_adr_i, `TMSEQ_IDX_IRQ_STATUS);
  wire wr_imsk  = wr_lane0 & hit(wb_adr_i, `TMSEQ_IDX_IRQ_MASK);

  // ============================================================
  // control byte with commit delay
  reg [7:0]  ctl;
  reg [7:0]  ctl_pend;
  reg        busy;
  reg [31:0] commit_cnt;
  wire       ctl_accept = wr_ctl & ~busy;
  wire       ctl_reject = wr_ctl & busy;
  wire       commit_now = busy & (commit_cnt == 32'h00000000);

  // reserved and busy bits are not stored
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_pend <= `TMSEQ_CTL_RESET;
    end else if (ctl_accept) begin
      ctl_pend <= wb_dat_i[7:0] & `TMSEQ_CTL_WMASK;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else if (ctl_accept) begin
      busy <= 1'b1;
    end else if (commit_now) begin
      busy <= 1'b0;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      commit_cnt <= 32'h00000000;
    end else if (ctl_accept) begin
      commit_cnt <= COMMIT_CYCLES - 1;
    end else if (busy && commit_cnt != 32'h00000000) begin
      commit_cnt <= commit_cnt - 32'h00000001;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl <= `TMSEQ_CTL_RESET;
    end else if (commit_now) begin
      ctl <= ctl_pend;
    end
  end

  wire [2:0] period = ctl[`TMSEQ_CTL_PER_MSB:`TMSEQ_CTL_PER_LSB];
  assign battery_measure_en = ctl[`TMSEQ_CTL_BAT];
  // supply choice is registered so the pin cannot glitch
  reg        pwr_q;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= ctl[`TMSEQ_CTL_PWR] & ~sleep_sync;
    end
  end
  assign sensor_power_sel = pwr_q;

  // ============================================================
  // seconds timebase and period counter
  // seconds between automatic starts for periods 1 to 6
  function [9:0] period_len;
    input [2:0] per;
    reg   [3:0] shift;
    begin
      shift      = {1'b0, per} + 4'h3;
      period_len = 10'h001 << shift;
    end
  endfunction

  reg [31:0] sec_cnt;
  reg [9:0]  per_sec;
  wire       sec_tick = (sec_cnt == SECOND_CYCLES - 1);
  wire [9:0] per_len  = period_len(period);
  reg        per_due;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_cnt <= 32'h00000000;
    end else begin
      sec_cnt <= sec_tick ? 32'h00000000 : sec_cnt + 32'h00000001;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_sec <= 10'h000;
      per_due <= 1'b0;
    end else begin
      if (period == 3'h0 || period == 3'h7) begin
        per_sec <= 10'h000;
        per_due <= 1'b0;
      end else if (state == ST_IDLE && per_due) begin
        per_due <= 1'b0;
      end else if (sec_tick) begin
        if (per_sec >= per_len - 10'h001) begin
          per_sec <= 10'h000;
          per_due <= 1'b1;
        end else begin
          per_sec <= per_sec + 10'h001;
        end
      end
    end
  end

  // ============================================================
  // measurement sequencer
  reg        trig;
  reg        oneshot;
  reg [10:0] result;
  // no sleep gating on automatic starts
  wire auto_go = (period == 3'h7) | per_due;
  wire shot_go = (period == 3'h0) & trig & ~sleep_sync;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (auto_go | shot_go) next_state = ST_CONV;
      ST_CONV: if (done_rise) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  wire leave_idle = (state == ST_IDLE) && (next_state == ST_CONV);

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= leave_idle;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oneshot <= 1'b0;
    end else if (leave_idle) begin
      oneshot <= shot_go & ~auto_go;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= 11'h000;
    end else if (state == ST_CONV && done_rise) begin
      result <= res_sync;
    end
  end

  // trigger bit; a software set wins over the hardware clear
  wire shot_end = (state == ST_DONE) & oneshot;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig <= 1'b0;
    end else if (wr_trg && wb_dat_i[`TMSEQ_TRG_START] && !sleep_sync) begin
      trig <= 1'b1;
    end else if (shot_end) begin
      trig <= 1'b0;
    end
  end

  // ============================================================
  // interrupts: done and rejected write, write one to clear
  reg [`TMSEQ_IRQ_WIDTH-1:0] ists;
  reg [`TMSEQ_IRQ_WIDTH-1:0] imsk;
  wire [`TMSEQ_IRQ_WIDTH-1:0] ev = {ctl_reject, state == ST_DONE};
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ists <= {`TMSEQ_IRQ_WIDTH{1'b0}};
    end else begin
      ists <= (ists & ~(wr_ists ? wb_dat_i[`TMSEQ_IRQ_WIDTH-1:0] : 2'b00)) | ev;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      imsk <= {`TMSEQ_IRQ_WIDTH{1'b0}};
    end else if (wr_imsk) begin
      imsk <= wb_dat_i[`TMSEQ_IRQ_WIDTH-1:0];
    end
  end

  reg irq_q;
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ists & imsk);
    end
  end
  assign irq = irq_q;

  // ============================================================
  // read mux and acknowledge
  reg [7:0] rd;
  always @* begin
    rd = 8'h00;
    if (hit(wb_adr_i, `TMSEQ_IDX_REF22_HIGH))
      rd = {5'h00, REF22_VALUE[10:8]};
    else if (hit(wb_adr_i, `TMSEQ_IDX_REF22_LOW))
      rd = REF22_VALUE[7:0];
    else if (hit(wb_adr_i, `TMSEQ_IDX_RESULT_HIGH))
      rd = result[10:3];
    else if (hit(wb_adr_i, `TMSEQ_IDX_RESULT_LOW))
      rd = {result[2:0], 5'h00};
    else if (hit(wb_adr_i, `TMSEQ_IDX_CONTROL))
      rd = {ctl[7:4], busy, ctl[2:0]};
    else if (hit(wb_adr_i, `TMSEQ_IDX_TRIGGER))
      rd = {1'b0, trig, 6'h00};
    else if (hit(wb_adr_i, `TMSEQ_IDX_IRQ_STATUS))
      rd = {6'h00, ists};
    else if (hit(wb_adr_i, `TMSEQ_IDX_IRQ_MASK))
      rd = {6'h00, imsk};
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= bus_req ? {24'h000000, rd} : 32'h00000000;
    end
  end

endmodule

// >>> tmseq_defs.vh
// register offsets, field positions, reset values and timing for the temperature sequencer
`ifndef TMSEQ_DEFS_VH
`define TMSEQ_DEFS_VH
// ============================================================
// register indices (byte address is four times the index)
`define TMSEQ_IDX_REF22_HIGH   16'h230A
`define TMSEQ_IDX_REF22_LOW    16'h230B
`define TMSEQ_IDX_RESULT_HIGH  16'h2881
`define TMSEQ_IDX_RESULT_LOW   16'h2882
`define TMSEQ_IDX_CONTROL      16'h28A0
`define TMSEQ_IDX_TRIGGER      16'h28B4
`define TMSEQ_IDX_IRQ_STATUS   16'h28C0
`define TMSEQ_IDX_IRQ_MASK     16'h28C1
// ============================================================
// temp_control fields
`define TMSEQ_CTL_PER_MSB      2
`define TMSEQ_CTL_PER_LSB      0
`define TMSEQ_CTL_BUSY         3
`define TMSEQ_CTL_BAT          4
`define TMSEQ_CTL_PWR          6
`define TMSEQ_CTL_RSVD         7
`define TMSEQ_CTL_RESET        8'h00
`define TMSEQ_CTL_WMASK        8'h77
// oneshot_trigger_byte field
`define TMSEQ_TRG_START        6
// interrupt status bits
`define TMSEQ_IRQ_DONE         0
`define TMSEQ_IRQ_REJECT       1
`define TMSEQ_IRQ_WIDTH        2
// ============================================================
// timing
`define TMSEQ_CLK_HZ           10000000
`define TMSEQ_COMMIT_US        6000
`define TMSEQ_COMMIT_CYCLES    ((`TMSEQ_COMMIT_US * (`TMSEQ_CLK_HZ / 1000000)))
`define TMSEQ_SECOND_CYCLES    `TMSEQ_CLK_HZ
`endif

// >>> tmseq_monitor.sv
// assertion checker on the temperature sequencer ports
`include "tmseq_defs.vh"
module tmseq_monitor #(parameter int COMMIT_CYCLES = 20) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sleep_mode,
  input wire logic        conv_start,
  input wire logic        battery_measure_en,
  input wire logic        sensor_power_sel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence asleep_s; sleep_mode [*4]; endsequence
  // ============================================================
  // cycles since the last accepted control write, saturating
  int   cnt;
  logic ctl_wr;
  assign ctl_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i == {`TMSEQ_IDX_CONTROL, 2'b00};
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst) cnt <= COMMIT_CYCLES;
    else if (ctl_wr && cnt >= COMMIT_CYCLES) cnt <= 0;
    else if (cnt < COMMIT_CYCLES) cnt <= cnt + 1;
  ack_after_req_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_in_cycle_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack outside a cycle");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  data_byte_a: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data bits set");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  sleep_power_a: assert property (asleep_s |-> !sensor_power_sel)
    else $error("sensor not on battery in sleep");
  commit_delay_a: assert property ($changed(battery_measure_en) |->
    cnt == COMMIT_CYCLES && $past(cnt) == COMMIT_CYCLES - 1)
    else $error("control committed at wrong time");
endmodule
bind tmseq_core tmseq_monitor #(.COMMIT_CYCLES(COMMIT_CYCLES)) tmseq_monitor_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sleep_mode(sleep_mode), .conv_start(conv_start),
  .battery_measure_en(battery_measure_en), .sensor_power_sel(sensor_power_sel));
